// File: rtl/lcm_gate.sv
// legacy compatibility mode gating with an ahb-lite status port
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "lcm_defines.svh"

// What this block does
// R01 - extra I/O only via load/store space
// R02 - legacy I/O addresses stay unchanged
// R03 - compat: extended I/O off, legacy RAM
// R04 - compat: extended vectors removed
// R05 - compat: one async USART, 8-bit baud
// R06 - compat: one 16-bit timer, two compares
// R07 - compat: two-wire interface unavailable
// R08 - compat: third port output only
// R09 - compat: five-bit port alternate only
// R10 - compat: analogue port digital input only
// R11 - compat: boot loader disabled
// R12 - compat: oscillator calibration writes ignored
// R13 - compat: no pin release, single wait-state
// R14 - compat: only external, power-on reset flags
// R15 - compat: watchdog change needs no sequence
// R16 - compat: ext interrupts 3..0 level only
// R17 - compat: receiver without FIFO
// R18 - software writes zero to unused bits
// R19 - fuse latched at reset, held
module lcm_gate
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // fuse and reset cause
    input  wire logic        legacy_compat_fuse,
    input  wire logic        power_on_reset_flag,
    input  wire logic        external_reset_flag,
    input  wire logic [4:0]  reset_cause_all,
    // cpu data access probe
    input  wire logic        cpu_io_short,
    input  wire logic [15:0] cpu_data_addr,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output      logic [31:0] hrdata,
    output      logic        hreadyout,
    output      logic        hresp,
    // mode and gating outputs
    output      logic        compat_mode,
    output      logic [18:0] gate,
    output      logic        ext_io_hit,
    output      logic [15:0] ram_base,
    output      logic [7:0]  vector_count,
    output      logic [11:0] baud_mask,
    output      logic [1:0]  rx_fifo_depth,
    output      logic [3:0]  extint_level_only,
    output      logic [7:0]  mcu_reset_status_reg
);
    logic                rst_n;
    lcm_pkg::lcm_regs_t  r;
    lcm_pkg::lcm_regs_t  next_r;
    logic                ext_region;
    logic                req;
    logic                io_set;
    logic                io_clr;

    lcm_rst_sync u_rst
    (
        .clock     (clock),
        .rstn      (rstn),
        .rstn_sync (rst_n)
    );

    // ======================================================
    // helpers
    function automatic logic in_ext_io(input logic [15:0] a);
        in_ext_io = (a >= `LCM_EXT_IO_LO) && (a <= `LCM_EXT_IO_HI);
    endfunction

    // only the two legacy causes survive; every other bit reads zero
    function automatic logic [7:0] legacy_flags(input logic ext, input logic por);
        legacy_flags              = 8'h00;
        legacy_flags[`LCM_RS_EXT] = ext;
        legacy_flags[`LCM_RS_POR] = por;
    endfunction

    function automatic logic [7:0] native_flags(input logic [4:0] cause);
        native_flags = {3'h0, cause} & `LCM_RS_MASK_FULL;
    endfunction

    assign ext_region = in_ext_io(cpu_data_addr);
    assign req        = hsel && hready && htrans[1];
    assign io_set     = cpu_io_short && ext_region;
    assign io_clr     = r.dp_valid && r.dp_write && r.dp_addr == `LCM_OFF_IOCHK && hwdata[0];

    // ======================================================
    // next state
    always_comb
    begin
        next_r          = r;
        next_r.dp_valid = req;
        if (req)
        begin
            next_r.dp_write = hwrite;
            next_r.dp_addr  = haddr;
        end
        case (r.state)
            lcm_pkg::LCM_ST_RESET:
            begin
                next_r.state = lcm_pkg::LCM_ST_LATCH;
            end
            lcm_pkg::LCM_ST_LATCH:
            begin
                // fuse taken once after release, then frozen
                next_r.compat    = legacy_compat_fuse; // R19
                next_r.rst_flags = legacy_compat_fuse
                    ? legacy_flags(external_reset_flag, power_on_reset_flag) // R14
                    : native_flags(reset_cause_all);
                next_r.state     = lcm_pkg::LCM_ST_RUN;
            end
            lcm_pkg::LCM_ST_RUN:
            begin
                next_r.state = lcm_pkg::LCM_ST_RUN;
            end
            default:
            begin
                next_r.state = lcm_pkg::LCM_ST_RESET;
            end
        endcase
        // short in/out form cannot reach the extended space
        if (io_set)
        begin
            next_r.io_err = 1'b1; // R01
        end
        // write-one clears, a new event wins
        else if (io_clr)
        begin
            next_r.io_err = 1'b0;
        end
        if (req && !hwrite)
        begin
            case (haddr)
                `LCM_OFF_MODE:    next_r.hrdata = {31'h0, r.compat};
                `LCM_OFF_GATE:    next_r.hrdata = {13'h0, gate};
                `LCM_OFF_RSTSTAT: next_r.hrdata = {24'h0, r.rst_flags};
                `LCM_OFF_IOCHK:   next_r.hrdata = {31'h0, r.io_err};
                default:          next_r.hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ======================================================
    // gating outputs; every gate bit derives from the latched mode only
    always_comb
    begin
        gate                      = '0;
        gate[`LCM_G_EXTIO]        = r.compat; // R03
        gate[`LCM_G_EXTVEC]       = r.compat; // R04
        gate[`LCM_G_USART1]       = r.compat; // R05
        gate[`LCM_G_USART_SYNC]   = r.compat; // R05
        gate[`LCM_G_BAUD_HI]      = r.compat; // R05
        gate[`LCM_G_TIMER3]       = r.compat; // R06
        gate[`LCM_G_OCC]          = r.compat; // R06
        gate[`LCM_G_TWI]          = r.compat; // R07
        gate[`LCM_G_PC_OUT]       = r.compat; // R08
        gate[`LCM_G_PG_ALT]       = r.compat; // R09
        gate[`LCM_G_PF_IN]        = r.compat; // R10
        gate[`LCM_G_BOOT]         = r.compat; // R11
        gate[`LCM_G_OSCCAL]       = r.compat; // R12
        gate[`LCM_G_XMEM_REL]     = r.compat; // R13
        gate[`LCM_G_XMEM_WS]      = r.compat; // R13
        gate[`LCM_G_RSTFLAGS]     = r.compat; // R14
        gate[`LCM_G_WDT_TIMED]    = r.compat; // R15
        gate[`LCM_G_INT_EDGE]     = r.compat; // R16
        gate[`LCM_G_USART_FIFO]   = r.compat; // R17
    end

    assign compat_mode          = r.compat;
    // legacy I/O below the extended region is never moved
    assign ext_io_hit           = ext_region && !r.compat; // R02
    assign ram_base             = r.compat ? `LCM_RAM_BASE_OLD : `LCM_RAM_BASE_NEW; // R03
    assign vector_count         = r.compat ? `LCM_VEC_LEGACY : `LCM_VEC_NATIVE; // R04
    assign baud_mask            = r.compat ? `LCM_BAUD_MASK_LEGACY : `LCM_BAUD_MASK_FULL; // R05
    assign rx_fifo_depth        = r.compat ? `LCM_RX_DEPTH_LEGACY : `LCM_RX_DEPTH_FULL; // R17
    assign extint_level_only    = r.compat ? `LCM_EXTINT_LEVEL : 4'h0; // R16
    assign mcu_reset_status_reg = r.rst_flags;
    assign hrdata               = r.hrdata;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;

    // ======================================================
    // checks
    chk_mode_held: assert property (@(posedge clock) disable iff (!rst_n) // R19
        r.state == lcm_pkg::LCM_ST_RUN |=> $stable(r.compat))
        else $error("compat mode changed after latch");
    chk_mode_latch: assert property (@(posedge clock) disable iff (!rst_n) // R19
        r.state == lcm_pkg::LCM_ST_LATCH |=> r.compat == $past(legacy_compat_fuse))
        else $error("fuse not latched");
    chk_ram_map: assert property (@(posedge clock) disable iff (!rst_n) // R03
        r.compat |-> ram_base == `LCM_RAM_BASE_OLD && !ext_io_hit)
        else $error("ram not at legacy place");
    chk_vec_count: assert property (@(posedge clock) disable iff (!rst_n) // R04
        r.compat |-> vector_count == `LCM_VEC_LEGACY)
        else $error("extended vectors present");
    chk_baud_low: assert property (@(posedge clock) disable iff (!rst_n) // R05
        r.compat |-> baud_mask == `LCM_BAUD_MASK_LEGACY && gate[`LCM_G_USART1])
        else $error("baud mask too wide");
    chk_rst_flags: assert property (@(posedge clock) disable iff (!rst_n) // R14
        r.compat |-> (r.rst_flags & ~`LCM_RS_MASK_LEGACY) == 8'h00)
        else $error("extra reset flags");
    chk_int_level: assert property (@(posedge clock) disable iff (!rst_n) // R16
        r.compat |-> extint_level_only == `LCM_EXTINT_LEVEL)
        else $error("edge sensing left on");
    chk_fifo_off: assert property (@(posedge clock) disable iff (!rst_n) // R17
        r.compat |-> rx_fifo_depth == `LCM_RX_DEPTH_LEGACY)
        else $error("receiver fifo left on");
    chk_short_io: assert property (@(posedge clock) disable iff (!rst_n) // R01
        cpu_io_short && ext_region |=> r.io_err)
        else $error("short io into extended space not flagged");
    chk_gate_all: assert property (@(posedge clock) disable iff (!rst_n) // R07
        gate == (r.compat ? {`LCM_NGATE{1'b1}} : {`LCM_NGATE{1'b0}}))
        else $error("gate vector inconsistent");
    chk_extio_off: assert property (@(posedge clock) disable iff (!rst_n) // R03
        r.compat |-> gate[`LCM_G_EXTIO])
        else $error("extended io left on");
    chk_ext_vec: assert property (@(posedge clock) disable iff (!rst_n) // R04
        r.compat |-> gate[`LCM_G_EXTVEC])
        else $error("extended vector gate off");
    chk_usart_async: assert property (@(posedge clock) disable iff (!rst_n) // R05
        r.compat |-> gate[`LCM_G_USART_SYNC] && gate[`LCM_G_BAUD_HI])
        else $error("usart sync or high baud left on");
    chk_timer_one: assert property (@(posedge clock) disable iff (!rst_n) // R06
        r.compat |-> gate[`LCM_G_TIMER3] && gate[`LCM_G_OCC])
        else $error("second timer or third compare left on");
    chk_twi_off: assert property (@(posedge clock) disable iff (!rst_n) // R07
        r.compat |-> gate[`LCM_G_TWI])
        else $error("two-wire interface left on");
    chk_port_c_out: assert property (@(posedge clock) disable iff (!rst_n) // R08
        r.compat |-> gate[`LCM_G_PC_OUT])
        else $error("third port not output only");
    chk_port_g_alt: assert property (@(posedge clock) disable iff (!rst_n) // R09
        r.compat |-> gate[`LCM_G_PG_ALT])
        else $error("five-bit port still general io");
    chk_port_f_in: assert property (@(posedge clock) disable iff (!rst_n) // R10
        r.compat |-> gate[`LCM_G_PF_IN])
        else $error("analogue port may drive");
    chk_boot_off: assert property (@(posedge clock) disable iff (!rst_n) // R11
        r.compat |-> gate[`LCM_G_BOOT])
        else $error("boot loader left on");
    chk_osc_fixed: assert property (@(posedge clock) disable iff (!rst_n) // R12
        r.compat |-> gate[`LCM_G_OSCCAL])
        else $error("oscillator calibration writable");
    chk_xmem_fixed: assert property (@(posedge clock) disable iff (!rst_n) // R13
        r.compat |-> gate[`LCM_G_XMEM_REL] && gate[`LCM_G_XMEM_WS])
        else $error("external memory options left on");
    chk_wdt_free: assert property (@(posedge clock) disable iff (!rst_n) // R15
        r.compat |-> gate[`LCM_G_WDT_TIMED])
        else $error("watchdog sequence still required");
    chk_native_map: assert property (@(posedge clock) disable iff (!rst_n) // R02
        !r.compat |-> ram_base == `LCM_RAM_BASE_NEW && ext_io_hit == ext_region)
        else $error("native map wrong");
    chk_flags_legacy: assert property (@(posedge clock) disable iff (!rst_n) // R14
        r.state == lcm_pkg::LCM_ST_LATCH && legacy_compat_fuse |=>
        r.rst_flags == {6'h00, $past(external_reset_flag), $past(power_on_reset_flag)})
        else $error("legacy reset flags not latched");
    chk_flags_native: assert property (@(posedge clock) disable iff (!rst_n) // R19
        r.state == lcm_pkg::LCM_ST_LATCH && !legacy_compat_fuse |=>
        r.rst_flags == {3'h0, $past(reset_cause_all)})
        else $error("native reset flags not latched");
    chk_io_clear: assert property (@(posedge clock) disable iff (!rst_n) // R01
        io_clr && !io_set |=> !r.io_err)
        else $error("io flag not cleared");
    chk_io_hold: assert property (@(posedge clock) disable iff (!rst_n) // R01
        !io_set && !io_clr |=> $stable(r.io_err))
        else $error("io flag moved by itself");
    chk_read_mode: assert property (@(posedge clock) disable iff (!rst_n) // R19
        req && !hwrite && haddr == `LCM_OFF_MODE |=> hrdata == {31'h0, compat_mode})
        else $error("mode read wrong");
    chk_read_flags: assert property (@(posedge clock) disable iff (!rst_n) // R14
        req && !hwrite && haddr == `LCM_OFF_RSTSTAT |=> hrdata == {24'h0, mcu_reset_status_reg})
        else $error("reset status read wrong");
    chk_state_order: assert property (@(posedge clock) disable iff (!rst_n) // R19
        r.state == lcm_pkg::LCM_ST_LATCH |=> r.state == lcm_pkg::LCM_ST_RUN)
        else $error("latch not left for run");

    cov_compat: cover property (@(posedge clock) disable iff (!rst_n)
        r.state == lcm_pkg::LCM_ST_RUN && r.compat);
    cov_native: cover property (@(posedge clock) disable iff (!rst_n)
        r.state == lcm_pkg::LCM_ST_RUN && !r.compat);
    cov_ioerr: cover property (@(posedge clock) disable iff (!rst_n) r.io_err);
    cov_read: cover property (@(posedge clock) disable iff (!rst_n) req && !hwrite);
    cov_clear: cover property (@(posedge clock) disable iff (!rst_n) io_clr && !io_set);
endmodule

// File: rtl/lcm_defines.svh
// constants for the legacy compatibility gating block
`ifndef LCM_DEFINES_SVH
`define LCM_DEFINES_SVH

// ======================================================
// register map
`define LCM_OFF_MODE        12'h000
`define LCM_OFF_GATE        12'h004
`define LCM_OFF_RSTSTAT     12'h008
`define LCM_OFF_IOCHK       12'h00c

// ======================================================
// address map figures
`define LCM_LEGACY_IO_LOCS  8'h40
`define LCM_IO_BASE         16'h0020
`define LCM_EXT_IO_LO       16'h0060
`define LCM_EXT_IO_HI       16'h00ff
`define LCM_RAM_BASE_NEW    16'h0100
`define LCM_RAM_BASE_OLD    16'h0060
`define LCM_VEC_NATIVE      8'h23
`define LCM_VEC_LEGACY      8'h18

// ======================================================
// field positions of the gate register
`define LCM_G_EXTIO         0
`define LCM_G_EXTVEC        1
`define LCM_G_USART1        2
`define LCM_G_USART_SYNC    3
`define LCM_G_BAUD_HI       4
`define LCM_G_TIMER3        5
`define LCM_G_OCC           6
`define LCM_G_TWI           7
`define LCM_G_PC_OUT        8
`define LCM_G_PG_ALT        9
`define LCM_G_PF_IN         10
`define LCM_G_BOOT          11
`define LCM_G_OSCCAL        12
`define LCM_G_XMEM_REL      13
`define LCM_G_XMEM_WS       14
`define LCM_G_RSTFLAGS      15
`define LCM_G_WDT_TIMED     16
`define LCM_G_INT_EDGE      17
`define LCM_G_USART_FIFO    18
`define LCM_NGATE           19

// ======================================================
// reset status fields and masks, interrupt, baud and receiver settings
`define LCM_RS_POR          0
`define LCM_RS_EXT          1
`define LCM_RS_MASK_FULL    8'h1f
`define LCM_RS_MASK_LEGACY  8'h03
`define LCM_EXTINT_LEVEL    4'hf
`define LCM_BAUD_MASK_LEGACY 12'h0ff
`define LCM_BAUD_MASK_FULL  12'hfff
`define LCM_RX_DEPTH_FULL   2'h2
`define LCM_RX_DEPTH_LEGACY 2'h0

`endif

// File: rtl/lcm_pkg.sv
// types for the legacy compatibility gating block
package lcm_pkg;
    typedef enum logic [1:0] {
        LCM_ST_RESET = 2'b00,
        LCM_ST_LATCH = 2'b01,
        LCM_ST_RUN   = 2'b11
    } lcm_state_t;

    typedef struct packed {
        lcm_state_t  state;
        logic        compat;
        logic [7:0]  rst_flags;
        logic        io_err;
        logic [31:0] hrdata;
        logic        dp_valid;
        logic        dp_write;
        logic [11:0] dp_addr;
    } lcm_regs_t;

    typedef struct packed {
        logic [1:0] sync;
    } lcm_sync_t;
endpackage

// File: rtl/lcm_rst_sync.sv
// reset release synchroniser for the gating block
`timescale 1ns/1ps
module lcm_rst_sync
(
    // clock and raw reset
    input  wire logic clock,
    input  wire logic rstn,
    // released reset
    output      logic rstn_sync
);
    lcm_pkg::lcm_sync_t r;
    lcm_pkg::lcm_sync_t next_r;

    always_comb
    begin
        next_r      = r;
        next_r.sync = {r.sync[0], 1'b1};
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rstn_sync = r.sync[1];
endmodule

// File: dv/lcm_gate_tb_top.sv
// self-checking bench for the legacy compatibility gating block
`timescale 1ns/1ps
`include "lcm_defines.svh"
module lcm_gate_tb_top;
    logic        clock, rstn, legacy_compat_fuse, power_on_reset_flag, external_reset_flag;
    logic [4:0]  reset_cause_all;
    logic        cpu_io_short, hsel, hwrite, hready, hreadyout, hresp, compat_mode, ext_io_hit;
    logic [15:0] cpu_data_addr, ram_base;
    logic [11:0] haddr, baud_mask;
    logic [1:0]  htrans, rx_fifo_depth;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [18:0] gate;
    logic [7:0]  vector_count, mcu_reset_status_reg;
    logic [3:0]  extint_level_only;
    int          fail_count;
    int          checks_done;

    // one slave on the bus, so its ready is the bus ready
    assign hready = hreadyout;

    lcm_gate dut
    (
        .clock(clock), .rstn(rstn), .legacy_compat_fuse(legacy_compat_fuse),
        .power_on_reset_flag(power_on_reset_flag), .external_reset_flag(external_reset_flag),
        .reset_cause_all(reset_cause_all), .cpu_io_short(cpu_io_short),
        .cpu_data_addr(cpu_data_addr), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .compat_mode(compat_mode), .gate(gate),
        .ext_io_hit(ext_io_hit), .ram_base(ram_base), .vector_count(vector_count),
        .baud_mask(baud_mask), .rx_fifo_depth(rx_fifo_depth),
        .extint_level_only(extint_level_only), .mcu_reset_status_reg(mcu_reset_status_reg)
    );

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ======================================================
    // reporting
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ======================================================
    // ahb-lite master
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clock);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                check("hready wait", 32'h1, 32'(hready));
                summarize();
            end
            @(posedge clock);
        end
    endtask

    // entered just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] data);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        data = hrdata;
        check("hresp", 32'h0, 32'(hresp));
    endtask

    // ======================================================
    // sequences
    task automatic do_reset(input logic fuse, input logic por, input logic ext,
                            input logic [4:0] all);
        @(posedge clock);
        rstn <= 1'b0;
        legacy_compat_fuse <= fuse;
        power_on_reset_flag <= por;
        external_reset_flag <= ext;
        reset_cause_all <= all;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    task automatic check_mode(input logic c, input logic [7:0] rs);
        logic [31:0] g;
        g = c ? 32'h0007ffff : 32'h0;
        #1;
        check("compat_mode", 32'(c), 32'(compat_mode));
        check("gate", g, 32'(gate));
        check("ram_base", c ? `LCM_RAM_BASE_OLD : `LCM_RAM_BASE_NEW, 32'(ram_base));
        check("vector_count", c ? `LCM_VEC_LEGACY : `LCM_VEC_NATIVE, 32'(vector_count));
        check("baud_mask", c ? 32'h0ff : 32'hfff, 32'(baud_mask));
        check("rx_fifo_depth", c ? 32'h0 : 32'h2, 32'(rx_fifo_depth));
        check("extint_level_only", c ? 32'hf : 32'h0, 32'(extint_level_only));
        check("reset status", 32'(rs), 32'(mcu_reset_status_reg));
        @(posedge clock);
        bus(1'b0, `LCM_OFF_MODE, 32'h0, rd);
        check("mode reg", 32'(c), rd);
        bus(1'b0, `LCM_OFF_GATE, 32'h0, rd);
        check("gate reg", g, rd);
        bus(1'b0, `LCM_OFF_RSTSTAT, 32'h0, rd);
        check("reset status reg", 32'(rs), rd);
    endtask

    // entered just after a rising edge, leaves one edge later
    task automatic probe(input logic s, input logic [15:0] a, input logic hit);
        cpu_io_short <= s;
        cpu_data_addr <= a;
        #1;
        check("ext_io_hit", 32'(hit), 32'(ext_io_hit));
        @(posedge clock);
    endtask

    initial
    begin
        fail_count = 0;
        checks_done = 0;
        rstn = 1'b0;
        legacy_compat_fuse = 1'b0;
        power_on_reset_flag = 1'b0;
        external_reset_flag = 1'b0;
        reset_cause_all = 5'h00;
        cpu_io_short = 1'b0;
        cpu_data_addr = 16'h0000;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        do_reset(1'b0, 1'b1, 1'b0, 5'h15);
        check_mode(1'b0, 8'h15);
        // short access to legacy space must not flag
        probe(1'b1, 16'h0020, 1'b0);
        probe(1'b1, 16'h005f, 1'b0);
        probe(1'b0, 16'h0000, 1'b0);
        bus(1'b0, `LCM_OFF_IOCHK, 32'h0, rd);
        check("io check", 32'h0, rd);
        probe(1'b1, 16'h0060, 1'b1);
        probe(1'b1, 16'h00ff, 1'b1);
        probe(1'b0, 16'h0100, 1'b0);
        bus(1'b0, `LCM_OFF_IOCHK, 32'h0, rd);
        check("io check", 32'h1, rd);
        bus(1'b1, `LCM_OFF_IOCHK, 32'h1, rd);
        bus(1'b0, `LCM_OFF_IOCHK, 32'h0, rd);
        check("io check", 32'h0, rd);
        // read-only and unmapped places
        bus(1'b1, `LCM_OFF_MODE, 32'hffffffff, rd);
        bus(1'b0, `LCM_OFF_MODE, 32'h0, rd);
        check("mode reg", 32'h0, rd);
        bus(1'b1, 12'h010, 32'h5a5a5a5a, rd);
        bus(1'b0, 12'h010, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        // fuse moves after the latch: mode must hold
        legacy_compat_fuse <= 1'b1;
        reset_cause_all <= 5'h0a;
        repeat (4) @(posedge clock);
        check_mode(1'b0, 8'h15);
        do_reset(1'b1, 1'b1, 1'b0, 5'h1f);
        check_mode(1'b1, 8'h01);
        probe(1'b1, 16'h0060, 1'b0);
        probe(1'b0, 16'h0000, 1'b0);
        legacy_compat_fuse <= 1'b0;
        power_on_reset_flag <= 1'b0;
        external_reset_flag <= 1'b1;
        repeat (4) @(posedge clock);
        check_mode(1'b1, 8'h01);
        do_reset(1'b1, 1'b1, 1'b1, 5'h1a);
        check_mode(1'b1, 8'h03);
        summarize();
    end
endmodule
